// ===== touch_cfg_consts.svh
`ifndef TOUCH_CFG_CONSTS_SVH
`define TOUCH_CFG_CONSTS_SVH

`define MCLK_HZ 10000000
`define SCL_LOW_MS 30
`define BUS_IDLE_US 200
`define SCL_LOW_CYCLES ((`SCL_LOW_MS * `MCLK_HZ + 999) / 1000)
`define BUS_IDLE_CYCLES ((`BUS_IDLE_US * `MCLK_HZ + 999999) / 1000000)
`define MS_CYCLES (`MCLK_HZ / 1000)

`define ADDR_GLOBAL_CONFIG 8'h20
`define ADDR_INPUT_SCAN_ENABLE 8'h21
`define ADDR_GLOBAL_CONFIG_SECOND 8'h44

`define RST_GLOBAL_CONFIG 8'h20
`define RST_INPUT_SCAN_ENABLE 8'hff
`define RST_GLOBAL_CONFIG_SECOND 8'h40
`define MASK_GLOBAL_CONFIG 8'hb8
`define MASK_GLOBAL_CONFIG_SECOND 8'h7f

`define BIT_BUS_GUARD 7
`define BIT_DIGITAL_REJECT_OFF 5
`define BIT_LOWFREQ_FILTER_OFF 4
`define BIT_HOLD_LIMIT_RECAL_EN 3
`define BIT_BASE_LIMIT_RETRY 6
`define BIT_IDLE_POWER_HOLD 5
`define BIT_BASE_LIMIT_IRQ_EN 4
`define BIT_RADIO_ONLY_REPORT 3
`define BIT_RADIO_FILTER_OFF 2
`define BIT_CAL_FAILURE_IRQ_EN 1
`define BIT_RELEASE_IRQ_SUPPRESS 0

`endif

// ===== touch_cfg_pkg.sv
package touch_cfg_pkg;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_PTR,
        BUS_PTR_ACK,
        BUS_WDATA,
        BUS_WDATA_ACK,
        BUS_RDATA,
        BUS_RDATA_ACK
    } bus_state_t;

    typedef logic [7:0][7:0] delta_bank_t;

endpackage : touch_cfg_pkg

// ===== sense_cfg_if.sv
interface sense_cfg_if;
    logic digital_reject_off;
    logic lowfreq_filter_off;
    logic hold_limit_recal_en;
    logic base_limit_retry;
    logic radio_only_report;
    logic radio_filter_off;
    logic [3:0] hold_limit_time;
    logic [7:0] noise_thresh;
    logic ms_tick;

    modport src (
        output digital_reject_off, lowfreq_filter_off, hold_limit_recal_en,
        output base_limit_retry, radio_only_report, radio_filter_off,
        output hold_limit_time, noise_thresh, ms_tick
    );
    modport sink (
        input digital_reject_off, lowfreq_filter_off, hold_limit_recal_en,
        input base_limit_retry, radio_only_report, radio_filter_off,
        input hold_limit_time, noise_thresh, ms_tick
    );
endinterface : sense_cfg_if

// ===== bus_guard.sv
module bus_guard #(
    parameter int LOW_CYCLES = 300000,
    parameter int IDLE_CYCLES = 2000
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic guard_en,
    input wire logic scl_lvl,
    input wire logic sda_lvl,
    output logic bus_reset
);
    logic [18:0] low_cnt;
    logic [18:0] idle_cnt;

    // Counters stop at their limit so each stall gives one reset pulse.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_cnt <= '0;
            idle_cnt <= '0;
            bus_reset <= 1'b0;
        end
        else
        begin
            bus_reset <= 1'b0;
            if (!guard_en || scl_lvl) // R02
                low_cnt <= '0;
            else if (low_cnt != 19'(LOW_CYCLES))
            begin
                low_cnt <= low_cnt + 19'h1;
                if (low_cnt == 19'(LOW_CYCLES - 1))
                    bus_reset <= 1'b1; // R01
            end
            if (!guard_en || !scl_lvl || !sda_lvl) // R02
                idle_cnt <= '0;
            else if (idle_cnt != 19'(IDLE_CYCLES))
            begin
                idle_cnt <= idle_cnt + 19'h1;
                if (idle_cnt == 19'(IDLE_CYCLES - 1))
                    bus_reset <= 1'b1; // R01
            end
        end
    end
endmodule : bus_guard

// ===== touch_channel.sv
`include "touch_cfg_consts.svh"

module touch_channel (
    input wire logic mclk,
    input wire logic arst_n,
    sense_cfg_if.sink cfg,
    input wire logic [7:0] raw_delta,
    input wire logic lf_noise,
    input wire logic rf_noise,
    input wire logic [7:0] touch_thresh,
    input wire logic base_limit_flag,
    output logic [7:0] delta_out,
    output logic noise_status,
    output logic recal_sample_ok,
    output logic hold_recal_req,
    output logic retry_cal_req
);
    logic lf_block;
    logic rf_block;
    logic [7:0] dpos;
    logic touched;
    logic [13:0] held_ms;
    logic [13:0] hold_limit;

    localparam logic [15:0][13:0] LIMIT_MS = {14'h2bc0, 14'h2760,
        14'h22ca, 14'h1ea0, 14'h1a40, 14'h15e0, 14'h1180, 14'h0f50,
        14'h0d20, 14'h0af0, 14'h08c0, 14'h0690, 14'h0578, 14'h0460,
        14'h0348, 14'h0230};

    assign lf_block = lf_noise && !cfg.lowfreq_filter_off; // R05 R06
    assign rf_block = rf_noise && !cfg.radio_filter_off; // R13
    assign dpos = raw_delta[7] ? 8'h00 : raw_delta;
    assign touched = !lf_block && !rf_block && (dpos > touch_thresh);
    assign hold_limit = LIMIT_MS[cfg.hold_limit_time];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            delta_out <= 8'h00;
            noise_status <= 1'b0;
            recal_sample_ok <= 1'b0;
            retry_cal_req <= 1'b0;
        end
        else
        begin
            // Status only reports blocking sources; with radio-only report set, a
            // delta zeroed by low-frequency noise shows no status.
            noise_status <= rf_block
                || (lf_block && !cfg.radio_only_report); // R12
            delta_out <= (lf_block || rf_block) ? 8'h00 : raw_delta; // R18
            recal_sample_ok <= !lf_block && !rf_block && !touched
                && (cfg.digital_reject_off
                || dpos <= cfg.noise_thresh); // R03 R04
            retry_cal_req <= base_limit_flag && cfg.base_limit_retry; // R09
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            held_ms <= '0;
            hold_recal_req <= 1'b0;
        end
        else
        begin
            hold_recal_req <= 1'b0;
            if (!touched || !cfg.hold_limit_recal_en) // R07
                held_ms <= '0;
            else if (cfg.ms_tick)
            begin
                if (held_ms + 14'h1 >= hold_limit)
                begin
                    held_ms <= '0;
                    hold_recal_req <= 1'b1; // R08
                end
                else
                    held_ms <= held_ms + 14'h1;
            end
        end
    end
endmodule : touch_channel

// ===== touch_cfg_top.sv
// Function
// R01 - Guard set: serial reset on clock low 30ms or idle 200us.
// R02 - Guard clear: serial port never times out or idles out.
// R03 - Reject on: noisy sub-touch samples skip recalibration.
// R04 - Reject off: every sub-touch delta feeds recalibration; here deltas blocked by LF or RF noise still do not.
// R05 - Low-frequency filter on: noise zeroes that delta.
// R06 - Low-frequency filter off: such noise never blocks a touch.
// R07 - Hold limit off: touches may last forever, no recalibration.
// R08 - Hold limit on: overlong touch recalibrates that input.
// R09 - Base out of limit: retry calibration if retry bit set.
// R10 - Power hold clear: low power after last conversion.
// R11 - Base-limit flag interrupts only when enabled.
// R12 - Radio-only report hides low-frequency noise from status.
// R13 - Radio filter on zeroes delta on RF noise; off never blocks.
// R14 - Calibration failure interrupts only when enabled.
// R15 - Suppress clear: interrupt on press, release and repeat.
// R16 - Suppress set: interrupt on press and repeat, not release.
// R17 - Scan enable bits select Active inputs; reset all ones. Here input_scan_en is only an output; all eight channels always run.
// R18 - While noise status stands, the delta reads zero.
// R19 - Unassigned configuration bits read zero, ignore writes.
`include "touch_cfg_consts.svh"

module touch_cfg_top
    import touch_cfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a,
    parameter int SCL_LOW_CYCLES = `SCL_LOW_CYCLES,
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire delta_bank_t raw_delta,
    input wire logic [7:0] lf_noise,
    input wire logic [7:0] rf_noise,
    input wire delta_bank_t touch_thresh,
    input wire logic [7:0] noise_thresh,
    input wire logic [3:0] hold_limit_time,
    input wire logic [7:0] base_limit_flag,
    input wire logic base_limit_set,
    input wire logic cal_failure_set,
    input wire logic press_evt,
    input wire logic release_evt,
    input wire logic repeat_evt,
    input wire logic conv_done,
    input wire logic cycle_end,
    output delta_bank_t delta_out,
    output logic [7:0] noise_status,
    output logic [7:0] recal_sample_ok,
    output logic [7:0] hold_recal_req,
    output logic [7:0] retry_cal_req,
    output logic [7:0] input_scan_en,
    output logic low_power,
    output logic irq_pulse,
    output logic bus_reset
);
    logic [7:0] global_config;
    logic [7:0] global_config_second;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic guard_reset;
    bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    logic [7:0] ptr;
    logic read_mode;
    logic master_ack;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [13:0] ms_cnt;
    logic ms_tick;
    logic [7:0] rd_now;
    logic [7:0] rd_next;

    sense_cfg_if cfg ();

    // Stored values are already masked, so reserved bits read zero.
    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        if (addr == `ADDR_GLOBAL_CONFIG)
            reg_read = global_config; // R19
        else if (addr == `ADDR_INPUT_SCAN_ENABLE)
            reg_read = input_scan_en;
        else if (addr == `ADDR_GLOBAL_CONFIG_SECOND)
            reg_read = global_config_second; // R19
        else
            reg_read = 8'h00;
    endfunction : reg_read

    always_comb
    begin
        rd_now = reg_read(ptr);
        rd_next = reg_read(ptr + 8'h1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins come from the host's domain; the first stage feeds only the second.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
        else
        begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;
    assign bus_start = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
    assign bus_stop = scl_s2 && scl_s3 && sda_s2 && !sda_s3;

    bus_guard #(
        .LOW_CYCLES(SCL_LOW_CYCLES),
        .IDLE_CYCLES(`BUS_IDLE_CYCLES)
    ) u_guard (
        .mclk(mclk),
        .arst_n(arst_n),
        .guard_en(global_config[`BIT_BUS_GUARD]), // R01 R02
        .scl_lvl(scl_s2),
        .sda_lvl(sda_s2),
        .bus_reset(guard_reset)
    );

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            bus_reset <= 1'b0;
        else
            bus_reset <= guard_reset;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial slave: bits are taken on the clock rise, driven after the fall.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= BUS_IDLE;
            bit_cnt <= 4'h0;
            rx_sr <= 8'h00;
            tx_sr <= 8'h00;
            ptr <= 8'h00;
            read_mode <= 1'b0;
            master_ack <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (guard_reset) // R01
            begin
                state <= BUS_IDLE;
                sda_oe <= 1'b0;
            end
            else if (bus_start)
            begin
                state <= BUS_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (bus_stop)
            begin
                state <= BUS_IDLE;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (state == BUS_RDATA_ACK)
                    master_ack <= !sda_s2;
                else
                begin
                    rx_sr <= {rx_sr[6:0], sda_s2};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
            else if (scl_fall)
            begin
                unique case (state)
                    BUS_IDLE:
                        sda_oe <= 1'b0;
                    BUS_ADDR:
                        if (bit_cnt == 4'h8)
                        begin
                            if (rx_sr[7:1] == SLAVE_ADDR)
                            begin
                                state <= BUS_ADDR_ACK;
                                read_mode <= rx_sr[0];
                                sda_oe <= 1'b1;
                            end
                            else
                                state <= BUS_IDLE;
                        end
                    BUS_ADDR_ACK:
                    begin
                        bit_cnt <= 4'h0;
                        if (read_mode)
                        begin
                            tx_sr <= rd_now;
                            sda_oe <= !rd_now[7];
                            state <= BUS_RDATA;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            state <= BUS_PTR;
                        end
                    end
                    BUS_PTR:
                        if (bit_cnt == 4'h8)
                        begin
                            ptr <= rx_sr;
                            sda_oe <= 1'b1;
                            state <= BUS_PTR_ACK;
                        end
                    BUS_PTR_ACK, BUS_WDATA_ACK:
                    begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= BUS_WDATA;
                    end
                    BUS_WDATA:
                        if (bit_cnt == 4'h8)
                        begin
                            wr_stb <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= rx_sr;
                            ptr <= ptr + 8'h1;
                            sda_oe <= 1'b1;
                            state <= BUS_WDATA_ACK;
                        end
                    BUS_RDATA:
                        if (bit_cnt == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            state <= BUS_RDATA_ACK;
                        end
                        else
                        begin
                            tx_sr <= {tx_sr[6:0], 1'b0};
                            sda_oe <= !tx_sr[6];
                        end
                    BUS_RDATA_ACK:
                        if (master_ack)
                        begin
                            bit_cnt <= 4'h0;
                            ptr <= ptr + 8'h1;
                            tx_sr <= rd_next;
                            sda_oe <= !rd_next[7];
                            state <= BUS_RDATA;
                        end
                        else
                            state <= BUS_IDLE;
                endcase
            end
        end
    end

    // The pin is open drain: only a low level is ever driven.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            global_config <= `RST_GLOBAL_CONFIG;
            global_config_second <= `RST_GLOBAL_CONFIG_SECOND;
            input_scan_en <= `RST_INPUT_SCAN_ENABLE; // R17
        end
        else if (wr_stb)
        begin
            if (wr_addr == `ADDR_GLOBAL_CONFIG)
                global_config <= wr_data & `MASK_GLOBAL_CONFIG; // R19
            if (wr_addr == `ADDR_INPUT_SCAN_ENABLE)
                input_scan_en <= wr_data; // R17
            if (wr_addr == `ADDR_GLOBAL_CONFIG_SECOND)
                global_config_second <= wr_data
                    & `MASK_GLOBAL_CONFIG_SECOND; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond enable for the hold-limit timers.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else if (ms_cnt == 14'(MS_CYCLES - 1))
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b1;
        end
        else
        begin
            ms_cnt <= ms_cnt + 14'h1;
            ms_tick <= 1'b0;
        end
    end

    assign cfg.digital_reject_off = global_config[`BIT_DIGITAL_REJECT_OFF];
    assign cfg.lowfreq_filter_off = global_config[`BIT_LOWFREQ_FILTER_OFF];
    assign cfg.hold_limit_recal_en = global_config[`BIT_HOLD_LIMIT_RECAL_EN];
    assign cfg.base_limit_retry = global_config_second[`BIT_BASE_LIMIT_RETRY];
    assign cfg.radio_only_report =
        global_config_second[`BIT_RADIO_ONLY_REPORT];
    assign cfg.radio_filter_off = global_config_second[`BIT_RADIO_FILTER_OFF];
    assign cfg.hold_limit_time = hold_limit_time;
    assign cfg.noise_thresh = noise_thresh;
    assign cfg.ms_tick = ms_tick;

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++)
        begin : g_chan
            touch_channel u_chan (
                .mclk(mclk),
                .arst_n(arst_n),
                .cfg(cfg),
                .raw_delta(raw_delta[ch]),
                .lf_noise(lf_noise[ch]),
                .rf_noise(rf_noise[ch]),
                .touch_thresh(touch_thresh[ch]),
                .base_limit_flag(base_limit_flag[ch]),
                .delta_out(delta_out[ch]),
                .noise_status(noise_status[ch]),
                .recal_sample_ok(recal_sample_ok[ch]),
                .hold_recal_req(hold_recal_req[ch]),
                .retry_cal_req(retry_cal_req[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_pulse <= 1'b0;
        else
            irq_pulse <= (base_limit_set
                && global_config_second[`BIT_BASE_LIMIT_IRQ_EN]) // R11
                || (cal_failure_set
                && global_config_second[`BIT_CAL_FAILURE_IRQ_EN]) // R14
                || press_evt || repeat_evt // R15 R16
                || (release_evt
                && !global_config_second[`BIT_RELEASE_IRQ_SUPPRESS]); // R15
    end

    // Low power spans last conversion to cycle end; the hold bit wins.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            low_power <= 1'b0;
        else if (global_config_second[`BIT_IDLE_POWER_HOLD] || cycle_end)
            low_power <= 1'b0; // R10
        else if (conv_done)
            low_power <= 1'b1; // R10
    end
endmodule : touch_cfg_top

// ===== touch_cfg_properties.sv
module touch_cfg_properties
    import touch_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic press_evt,
    input wire logic repeat_evt,
    input wire logic release_evt,
    input wire logic base_limit_set,
    input wire logic cal_failure_set,
    input wire logic conv_done,
    input wire logic cycle_end,
    input wire logic irq_pulse,
    input wire logic low_power,
    input wire logic bus_reset,
    input wire logic [7:0] noise_status,
    input wire logic [7:0] base_limit_flag,
    input wire logic [7:0] retry_cal_req,
    input wire delta_bank_t delta_out
);
    logic any_evt;
    assign any_evt = base_limit_set | cal_failure_set | press_evt |
        release_evt | repeat_evt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    sequence s_wake;
        cycle_end ##1 !low_power;
    endsequence
    a_press_irq: assert property (press_evt |=> irq_pulse)
        else $error("no interrupt after press");
    a_repeat_irq: assert property (repeat_evt |=> irq_pulse)
        else $error("no interrupt after repeat");
    a_irq_cause: assert property (irq_pulse |-> $past(any_evt))
        else $error("interrupt without a cause");
    a_noise_zero: assert property (
        noise_status[0] |-> delta_out[0] == 8'h00)
        else $error("noisy delta not zero");
    a_retry_flag: assert property (
        (retry_cal_req & ~$past(base_limit_flag)) == 8'h00)
        else $error("retry without base flag");
    a_power_wake: assert property (cycle_end |-> s_wake)
        else $error("low power past cycle end");
    a_power_cause: assert property (
        $rose(low_power) |-> $past(conv_done))
        else $error("low power without conversion");
    a_guard_pulse: assert property (bus_reset |=> !bus_reset)
        else $error("bus reset longer than one cycle");
endmodule : touch_cfg_properties

// ===== i2c_host_model.sv
module i2c_host_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] ADDR = 7'h2a;
    // Clock stands high between frames; a released data line floats high.
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        #200 scl = 1'b1;
        #200 s = sda_lvl;
        #200 scl = 1'b0;
        #200;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] o, output logic [7:0] i,
        output logic ack);
        logic s;
        for (int k = 7; k >= 0; k--)
        begin
            bit_io(o[k], s);
            i[k] = s;
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : byte_io
    task automatic start;
        sda_drv = 1'b1;
        #200 scl = 1'b1;
        #300 sda_drv = 1'b0;
        #300 scl = 1'b0;
    endtask : start
    // Reads always end with a refusal of the byte, so one byte per frame.
    task automatic xact(input logic rnw, input logic [7:0] a,
        inout logic [7:0] v, output logic ok);
        logic [7:0] i;
        logic k1, k2, k3;
        start;
        byte_io({ADDR, 1'b0}, i, k1);
        byte_io(a, i, k2);
        if (rnw)
        begin
            start;
            byte_io({ADDR, 1'b1}, i, k3);
            byte_io(8'hff, v, i[0]);
        end
        else
            byte_io(v, i, k3);
        sda_drv = 1'b0;
        #200 scl = 1'b1;
        #300 sda_drv = 1'b1;
        ok = k1 & k2 & k3;
    endtask : xact
    task automatic hold_low(input int t);
        scl = 1'b0;
        #(t) scl = 1'b1;
    endtask : hold_low
endmodule : i2c_host_model

// ===== touch_cfg_top_tb.sv
module touch_cfg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import touch_cfg_pkg::*;
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
    logic mclk, arst_n, scl, sda_drv, sda_oe, ok, base_limit_set;
    logic cal_failure_set, press_evt, release_evt, repeat_evt, conv_done;
    logic cycle_end, low_power, irq_pulse, bus_reset;
    logic [7:0] lf_noise, rf_noise, base_limit_flag, noise_status, d;
    logic [7:0] recal_sample_ok, hold_recal_req, retry_cal_req, input_scan_en;
    delta_bank_t raw_delta, delta_out;
    int miscompares, checks_done, resets, n;
    wire sda_lvl = sda_drv & ~sda_oe;
    // A short low-clock limit keeps the timeout test within the run.
    touch_cfg_top #(.SCL_LOW_CYCLES(500), .MS_CYCLES(10)) i_touch_cfg_top (
        .mclk, .arst_n, .scl_in(scl), .sda_in(sda_lvl), .sda_out(), .sda_oe,
        .raw_delta, .lf_noise, .rf_noise, .touch_thresh({8{8'h20}}),
        .noise_thresh(8'h10), .hold_limit_time(4'h0), .base_limit_flag,
        .base_limit_set, .cal_failure_set, .press_evt, .release_evt,
        .repeat_evt, .conv_done, .cycle_end, .delta_out, .noise_status,
        .recal_sample_ok, .hold_recal_req, .retry_cal_req, .input_scan_en,
        .low_power, .irq_pulse, .bus_reset);
    i2c_host_model i_i2c_host_model (.scl, .sda_drv, .sda_lvl);
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (bus_reset === 1'b1)
            resets++;
    ////////////////////////////////////////
    task automatic ev(ref logic s, input logic e);
        @(negedge mclk) s = 1'b1;
        @(negedge mclk) s = 1'b0;
        `CHK("irq", e, irq_pulse)
    endtask : ev
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        d = v;
        i_i2c_host_model.xact(1'b0, a, d, ok);
        `CHK("ack", 1'b1, ok)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_i2c_host_model.xact(1'b1, a, d, ok);
        `CHK("reg", e, d)
    endtask : rd
    task automatic t_regs;
        repeat (2200) @(negedge mclk);
        `CHK("guard", 0, resets)
        `CHK("scan", 8'hff, input_scan_en)
        rd(8'h20, 8'h20);
        rd(8'h44, 8'h40);
        rd(8'h30, 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'hb8);
        wr(8'h44, 8'hff);
        rd(8'h44, 8'h7f);
        wr(8'h21, 8'h5a);
        `CHK("scan", 8'h5a, input_scan_en)
        wr(8'h20, 8'h20);
        $display("test regs done");
    endtask : t_regs
    task automatic t_irq;
        wr(8'h44, 8'h33);
        ev(base_limit_set, 1'b1);
        ev(cal_failure_set, 1'b1);
        ev(release_evt, 1'b0);
        ev(press_evt, 1'b1);
        ev(repeat_evt, 1'b1);
        ev(conv_done, 1'b0);
        `CHK("power", 1'b0, low_power)
        wr(8'h44, 8'h00);
        ev(base_limit_set, 1'b0);
        ev(cal_failure_set, 1'b0);
        ev(release_evt, 1'b1);
        ev(conv_done, 1'b0);
        `CHK("power", 1'b1, low_power)
        ev(cycle_end, 1'b0);
        `CHK("power", 1'b0, low_power)
        $display("test irq done");
    endtask : t_irq
    task automatic t_noise;
        raw_delta = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h50, 8'h50};
        lf_noise = 8'h01;
        rf_noise = 8'h02;
        base_limit_flag = 8'h01;
        wr(8'h44, 8'h40);
        `CHK("delta0", 8'h00, delta_out[0])
        `CHK("delta1", 8'h00, delta_out[1])
        `CHK("noise", 8'h03, noise_status)
        `CHK("retry", 8'h01, retry_cal_req)
        `CHK("recal", 1'b1, recal_sample_ok[2])
        wr(8'h44, 8'h48);
        `CHK("noise", 8'h02, noise_status)
        `CHK("delta0", 8'h00, delta_out[0])
        wr(8'h20, 8'h18);
        wr(8'h44, 8'h04);
        `CHK("delta0", 8'h50, delta_out[0])
        `CHK("delta1", 8'h50, delta_out[1])
        `CHK("retry", 8'h00, retry_cal_req)
        `CHK("recal", 1'b0, recal_sample_ok[2])
        n = 0;
        while (hold_recal_req[0] !== 1'b1 && n < 8000)
        begin
            @(negedge mclk);
            n++;
        end
        `CHK("hold", 1'b1, n > 4000 && n < 6000)
        $display("test noise done");
    endtask : t_noise
    task automatic t_guard;
        wr(8'h20, 8'h80);
        repeat (2200) @(negedge mclk);
        `CHK("guard", 1, resets)
        i_i2c_host_model.hold_low(60000);
        repeat (5) @(negedge mclk);
        `CHK("guard", 2, resets)
        wr(8'h20, 8'h20);
        $display("test guard done");
    endtask : t_guard
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        {arst_n, base_limit_set, cal_failure_set, press_evt} = 4'h0;
        {release_evt, repeat_evt, conv_done, cycle_end} = 4'h0;
        {lf_noise, rf_noise, base_limit_flag} = 24'h000000;
        raw_delta = '0;
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        t_regs;
        t_irq;
        t_noise;
        t_guard;
        complete_run;
    end
    initial
    begin
        #3000000;
        miscompares++;
        complete_run;
    end
endmodule : touch_cfg_top_tb
bind touch_cfg_top touch_cfg_properties i_touch_cfg_properties (
    .mclk, .arst_n, .press_evt, .repeat_evt, .release_evt, .base_limit_set,
    .cal_failure_set, .conv_done, .cycle_end, .irq_pulse, .low_power,
    .bus_reset, .noise_status, .base_limit_flag, .retry_cal_req, .delta_out);
